/* File: hdl/cru_call_return_unit.sv */
// call and return instruction unit with axi4-lite register access
`timescale 1ns/100ps
`default_nettype none

// Contract
// - decode relative call from 1101 1nnn word
// - push pc plus two before pc change
// - pc becomes pc plus two plus 2n
// - relative call one word, two cycles
// - soft reset restores state from second phase
// - interrupt return pops stack into pc
// - interrupt return sets one global enable
// - fast bit restores working, status, bank shadows
// - interrupt return word 0x001s, two cycles
// - returns leave pc latch registers unchanged
// - literal return loads literal into working
// - literal return pops pc, two cycles
module cru_call_return_unit (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic [20:0]      pc_o,
  output logic [7:0]       working_o,
  output logic [1:0]       phase_o,
  output logic             busy_o,
  output logic             soft_reset_o
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_relcall(input logic [15:0] iw);
    return iw[15:11] == cru_pkg::OP_RELCALL_HI;
  endfunction

  function automatic logic is_intret(input logic [15:0] iw);
    return iw[15:1] == cru_pkg::OP_INTRET_HI;
  endfunction

  function automatic logic is_litret(input logic [15:0] iw);
    return iw[15:8] == cru_pkg::OP_LITRET_HI;
  endfunction

  function automatic logic is_sreset(input logic [15:0] iw);
    return iw == cru_pkg::OP_SOFT_RESET;
  endfunction

  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    return a[4:2];
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a[7:5] == 3'h0) && (a[4:2] <= cru_pkg::IDX_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  cru_pkg::cru_state_t    state_r;
  cru_pkg::cru_state_t    state_nxt;
  logic [1:0]             phase_r;
  logic                   pend_r;
  logic [15:0]            ir_r;
  logic [15:0]            cur_r;
  logic [20:0]            pc_r;
  logic [20:0]            pc_nxt;
  logic [7:0]             w_r;
  logic [7:0]             w_nxt;
  logic [7:0]             st_r;
  logic [7:0]             st_nxt;
  logic [3:0]             bs_r;
  logic [3:0]             bs_nxt;
  logic [7:0]             ws_r;
  logic [7:0]             ss_r;
  logic [3:0]             bss_r;
  logic [7:0]             plh_r;
  logic [4:0]             plu_r;
  logic                   high_priority_global_enable_r;
  logic                   low_priority_global_enable_r;
  logic [4:0]             sp_r;
  logic [20:0]            stk_r [cru_pkg::STK_DEPTH];
  logic                   sreset_r;

  logic                   aw_hold_r;
  logic [7:0]             awaddr_r;
  logic                   w_hold_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   bvalid_r;
  logic [1:0]             bresp_r;
  logic                   rvalid_r;
  logic [31:0]            rdata_r;
  logic [1:0]             rresp_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  // sequencing and execution strobes

  wire busy_w   = (state_r != cru_pkg::CRU_IDLE) || pend_r;
  wire start_w  = (state_r == cru_pkg::CRU_IDLE) && pend_r &&
                  (phase_r == cru_pkg::PH_Q4);
  wire in_c1_w  = state_r == cru_pkg::CRU_CYC1;
  wire q2_w     = in_c1_w && (phase_r == cru_pkg::PH_Q2);
  wire q4_w     = in_c1_w && (phase_r == cru_pkg::PH_Q4);
  wire rc_w     = is_relcall(cur_r);
  wire ri_w     = is_intret(cur_r);
  wire rl_w     = is_litret(cur_r);
  wire sr_w     = is_sreset(cur_r);
  wire two_w    = rc_w || ri_w || rl_w;
  wire fast_w   = cur_r[cru_pkg::FAST_BIT];
  wire sres_w   = q2_w && sr_w;
  wire hard_w   = rst_i || sres_w;
  wire empty_w  = sp_r == cru_pkg::SP_RST;
  wire full_w   = sp_r == 5'(cru_pkg::STK_DEPTH);
  wire [20:0] top_w  = empty_w ? 21'h000000 : stk_r[sp_r - 5'h01];
  wire [20:0] ret_w  = pc_r + 21'h000002;
  wire [20:0] off_w  = {{9{cur_r[10]}}, cur_r[10:0], 1'b0};
  // push in first cycle before pc write
  wire push_w   = q2_w && rc_w && !full_w;
  wire pop_w    = q4_w && (ri_w || rl_w) && !empty_w;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cru_pkg::CRU_IDLE: begin
        if (start_w) state_nxt = cru_pkg::CRU_CYC1;
      end
      // two-cycle words add a no-operation cycle
      cru_pkg::CRU_CYC1: begin
        if (phase_r == cru_pkg::PH_Q4) begin
          state_nxt = two_w ? cru_pkg::CRU_CYC2 : cru_pkg::CRU_IDLE;
        end
      end
      cru_pkg::CRU_CYC2: begin
        if (phase_r == cru_pkg::PH_Q4) state_nxt = cru_pkg::CRU_IDLE;
      end
      default: state_nxt = cru_pkg::CRU_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // axi write decode

  wire        do_wr_w  = aw_hold_r && w_hold_r && !bvalid_r;
  wire [2:0]  widx_w   = reg_idx(awaddr_r);
  wire        wmap_w   = reg_mapped(awaddr_r) &&
                         (awaddr_r != cru_pkg::OFF_STACK);
  wire        wr_ok_w  = do_wr_w && wmap_w && !busy_w;
  wire [31:0] view_w [7];
  wire [31:0] wbase_w  = view_w[widx_w];
  wire [31:0] wval_w;
  wire        wr_ir_w  = wr_ok_w && (awaddr_r[4:2] == cru_pkg::OFF_INSTR[4:2]);
  wire        wr_pc_w  = wr_ok_w && (awaddr_r[4:2] == cru_pkg::OFF_PC[4:2]);
  wire        wr_wk_w  = wr_ok_w && (awaddr_r[4:2] == cru_pkg::OFF_WORK[4:2]);
  wire        wr_sh_w  = wr_ok_w &&
                         (awaddr_r[4:2] == cru_pkg::OFF_SHADOW[4:2]);
  wire        wr_la_w  = wr_ok_w &&
                         (awaddr_r[4:2] == cru_pkg::OFF_LATCH[4:2]);
  wire        wr_ct_w  = wr_ok_w && (awaddr_r[4:2] == cru_pkg::OFF_CTRL[4:2]);

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign wval_w[gb*8 +: 8] = wstrb_r[gb] ? wdata_r[gb*8 +: 8]
                                             : wbase_w[gb*8 +: 8];
    end
  endgenerate

  assign view_w[0] = {16'h0000, ir_r};
  assign view_w[1] = {11'h000, pc_r};
  assign view_w[2] = {12'h000, bs_r, st_r, w_r};
  assign view_w[3] = {12'h000, bss_r, ss_r, ws_r};
  assign view_w[4] = {19'h00000, plu_r, plh_r};
  assign view_w[5] = {3'h0, sp_r, 3'h0, top_w};
  assign view_w[6] = {21'h000000, phase_r, busy_w, 6'h00, low_priority_global_enable_r, high_priority_global_enable_r};

  ////////////////////////////////////////////////////////////////////////
  // next values of architectural registers

  // relative call target, pop into pc
  assign pc_nxt = (q4_w && rc_w)          ? ret_w + off_w :
                  (q4_w && (ri_w || rl_w)) ? top_w :
                  (q4_w && !sr_w)          ? ret_w :
                  wr_pc_w                  ? wval_w[20:0] : pc_r;
  assign w_nxt  = (q4_w && rl_w)           ? cur_r[7:0] :
                  (q4_w && ri_w && fast_w) ? ws_r :
                  wr_wk_w ? wval_w[cru_pkg::WORK_W_LSB +: 8] : w_r;
  assign st_nxt = (q4_w && ri_w && fast_w) ? ss_r :
                  wr_wk_w ? wval_w[cru_pkg::WORK_ST_LSB +: 8] : st_r;
  assign bs_nxt = (q4_w && ri_w && fast_w) ? bss_r :
                  wr_wk_w ? wval_w[cru_pkg::WORK_BS_LSB +: 4] : bs_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      phase_r  <= cru_pkg::PH_Q1;
      state_r  <= cru_pkg::CRU_IDLE;
      pend_r   <= 1'b0;
      ir_r     <= 16'h0000;
      cur_r    <= 16'h0000;
      sreset_r <= 1'b0;
    end else begin
      phase_r  <= phase_r + 2'h1;
      state_r  <= state_nxt;
      pend_r   <= wr_ir_w || (pend_r && !start_w);
      ir_r     <= wr_ir_w ? wval_w[15:0] : ir_r;
      cur_r    <= start_w ? ir_r : cur_r;
      sreset_r <= sres_w;
    end
  end

  // soft reset shares the hard reset values
  always_ff @(posedge core_clk_i) begin
    if (hard_w) begin
      pc_r   <= cru_pkg::PC_RST;
      w_r    <= cru_pkg::W_RST;
      st_r   <= cru_pkg::ST_RST;
      bs_r   <= cru_pkg::BS_RST;
      ws_r   <= cru_pkg::W_RST;
      ss_r   <= cru_pkg::ST_RST;
      bss_r  <= cru_pkg::BS_RST;
      plh_r  <= cru_pkg::PLH_RST;
      plu_r  <= cru_pkg::PLU_RST;
      high_priority_global_enable_r <= 1'b0;
      low_priority_global_enable_r <= 1'b0;
      sp_r   <= cru_pkg::SP_RST;
    end else begin
      pc_r <= pc_nxt;
      w_r  <= w_nxt;
      st_r <= st_nxt;
      bs_r <= bs_nxt;
      if (wr_sh_w) begin
        ws_r  <= wval_w[cru_pkg::WORK_W_LSB +: 8];
        ss_r  <= wval_w[cru_pkg::WORK_ST_LSB +: 8];
        bss_r <= wval_w[cru_pkg::WORK_BS_LSB +: 4];
      end
      // latches change only by register write
      if (wr_la_w) begin
        plh_r <= wval_w[7:0];
        plu_r <= wval_w[cru_pkg::LATCH_U_LSB +: 5];
      end
      // high enable first, else low enable
      if (q4_w && ri_w) begin
        high_priority_global_enable_r <= 1'b1;
        low_priority_global_enable_r <= low_priority_global_enable_r || high_priority_global_enable_r;
      end else if (wr_ct_w) begin
        high_priority_global_enable_r <= wval_w[cru_pkg::CTRL_HIGH_PRIORITY_GLOBAL_ENABLE];
        low_priority_global_enable_r <= wval_w[cru_pkg::CTRL_LOW_PRIORITY_GLOBAL_ENABLE];
      end
      sp_r <= push_w ? sp_r + 5'h01 : pop_w ? sp_r - 5'h01 : sp_r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push_w) stk_r[sp_r] <= ret_w;
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  wire aw_hs_w = s_axi_awvalid_i && s_axi_awready_o;
  wire w_hs_w  = s_axi_wvalid_i && s_axi_wready_o;
  wire ar_hs_w = s_axi_arvalid_i && s_axi_arready_o;

  assign s_axi_awready_o = !aw_hold_r && !bvalid_r;
  assign s_axi_wready_o  = !w_hold_r && !bvalid_r;
  assign s_axi_arready_o = !rvalid_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 8'h00;
      w_hold_r  <= 1'b0;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= cru_pkg::RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hs_w || (aw_hold_r && !do_wr_w);
      awaddr_r  <= aw_hs_w ? s_axi_awaddr_i : awaddr_r;
      w_hold_r  <= w_hs_w || (w_hold_r && !do_wr_w);
      wdata_r   <= w_hs_w ? s_axi_wdata_i : wdata_r;
      wstrb_r   <= w_hs_w ? s_axi_wstrb_i : wstrb_r;
      bvalid_r  <= do_wr_w || (bvalid_r && !s_axi_bready_i);
      if (do_wr_w) begin
        bresp_r <= wr_ok_w ? cru_pkg::RESP_OKAY : cru_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= cru_pkg::RESP_OKAY;
    end else begin
      rvalid_r <= ar_hs_w || (rvalid_r && !s_axi_rready_i);
      if (ar_hs_w) begin
        rdata_r <= reg_mapped(s_axi_araddr_i) ?
                   view_w[reg_idx(s_axi_araddr_i)] : 32'h00000000;
        rresp_r <= reg_mapped(s_axi_araddr_i) ? cru_pkg::RESP_OKAY
                                              : cru_pkg::RESP_SLVERR;
      end
    end
  end

  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o  = bresp_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o  = rdata_r;
  assign s_axi_rresp_o  = rresp_r;
  assign pc_o           = pc_r;
  assign working_o      = w_r;
  assign phase_o        = phase_r;
  assign busy_o         = busy_w;
  assign soft_reset_o   = sreset_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_relcall_decode;
    push_w |-> cur_r[15:12] == 4'hd && cur_r[11];
  endproperty
  a_relcall_decode: assert property (p_relcall_decode)
    else $error("push without relative call word");

  property p_relcall_push;
    push_w |=> sp_r == $past(sp_r) + 5'h01 && top_w == $past(pc_r) + 21'h2;
  endproperty
  a_relcall_push: assert property (p_relcall_push)
    else $error("return address not pushed");

  property p_relcall_target;
    q4_w && rc_w |=> pc_r == $past(pc_r) + 21'h2 + $past(off_w);
  endproperty
  a_relcall_target: assert property (p_relcall_target)
    else $error("relative call target wrong");

  property p_two_cycle;
    q4_w && two_w |=> state_r == cru_pkg::CRU_CYC2 [*4]
                      ##1 state_r == cru_pkg::CRU_IDLE;
  endproperty
  a_two_cycle: assert property (p_two_cycle)
    else $error("two-cycle word length wrong");

  property p_soft_reset;
    sres_w |=> pc_r == cru_pkg::PC_RST && w_r == cru_pkg::W_RST &&
               sp_r == cru_pkg::SP_RST && !high_priority_global_enable_r ##0 soft_reset_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore state");

  property p_intret_pop;
    q4_w && ri_w && !empty_w |=> pc_r == $past(top_w) &&
                                 sp_r == $past(sp_r) - 5'h01;
  endproperty
  a_intret_pop: assert property (p_intret_pop)
    else $error("interrupt return pop wrong");

  property p_intret_enable;
    q4_w && ri_w |=> high_priority_global_enable_r && (low_priority_global_enable_r || !$past(high_priority_global_enable_r));
  endproperty
  a_intret_enable: assert property (p_intret_enable)
    else $error("global enable not set");

  property p_fast_restore;
    q4_w && ri_w |=> fast_w ? (w_r == $past(ws_r) && st_r == $past(ss_r))
                            : (w_r == $past(w_r) && bs_r == $past(bs_r));
  endproperty
  a_fast_restore: assert property (p_fast_restore)
    else $error("shadow restore wrong");

  // soft reset is the one legal latch change while busy
  property p_latch_kept;
    busy_w && !sres_w |=> $stable(plh_r) && $stable(plu_r);
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("pc latch changed during execution");

  property p_litret;
    q4_w && rl_w && !empty_w |=> w_r == $past(cur_r[7:0]) &&
                                 pc_r == $past(top_w);
  endproperty
  a_litret: assert property (p_litret)
    else $error("literal return wrong");

endmodule

`default_nettype wire

/* File: hdl/cru_pkg.sv */
// constants and types shared by the call and return instruction unit
package cru_pkg;

  localparam int PC_W      = 21;
  localparam int SP_W      = 5;
  localparam int STK_DEPTH = 31;

  // instruction phases inside one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // opcode patterns
  localparam logic [4:0]  OP_RELCALL_HI = 5'h1b;
  localparam logic [14:0] OP_INTRET_HI  = 15'h0008;
  localparam logic [7:0]  OP_LITRET_HI  = 8'h0c;
  localparam logic [15:0] OP_SOFT_RESET = 16'h00ff;
  localparam int          FAST_BIT      = 0;

  // register byte offsets
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_PC     = 8'h04;
  localparam logic [7:0] OFF_WORK   = 8'h08;
  localparam logic [7:0] OFF_SHADOW = 8'h0c;
  localparam logic [7:0] OFF_LATCH  = 8'h10;
  localparam logic [7:0] OFF_STACK  = 8'h14;
  localparam logic [7:0] OFF_CTRL   = 8'h18;
  localparam logic [2:0] IDX_LAST   = 3'h6;

  // field positions
  localparam int WORK_W_LSB  = 0;
  localparam int WORK_ST_LSB = 8;
  localparam int WORK_BS_LSB = 16;
  localparam int LATCH_U_LSB = 8;
  localparam int STACK_SP_LSB = 24;
  localparam int CTRL_HIGH_PRIORITY_GLOBAL_ENABLE   = 0;
  localparam int CTRL_LOW_PRIORITY_GLOBAL_ENABLE   = 1;
  localparam int CTRL_BUSY   = 8;
  localparam int CTRL_PH_LSB = 9;

  // values after reset
  localparam logic [PC_W-1:0] PC_RST  = 21'h000000;
  localparam logic [7:0]      W_RST   = 8'h00;
  localparam logic [7:0]      ST_RST  = 8'h00;
  localparam logic [3:0]      BS_RST  = 4'h0;
  localparam logic [7:0]      PLH_RST = 8'h00;
  localparam logic [4:0]      PLU_RST = 5'h00;
  localparam logic [SP_W-1:0] SP_RST  = 5'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CRU_IDLE,
    CRU_CYC1,
    CRU_CYC2
  } cru_state_t;

endpackage

/* File: verification/cru_call_return_unit_test.sv */
// self-checking bench for the call and return instruction unit
`timescale 1ns/100ps
`default_nettype none
module cru_call_return_unit_test;
  typedef struct {
    string       name;
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0]  resp;
  } cru_exp_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        awv = 1'b0;
  logic [7:0]  awa = 8'h00;
  logic        wv  = 1'b0;
  logic [31:0] wd  = 32'h0;
  logic        bry = 1'b0;
  logic        arv = 1'b0;
  logic [7:0]  ara = 8'h00;
  logic        rry = 1'b0;
  logic        awr, wr, bv, arr, rv, busy, srst;
  logic [1:0]  br, rr, ph;
  logic [31:0] rd, r;
  logic [20:0] pc, pc0;
  logic [20:0] top[4];
  logic [10:0] n;
  logic [10:0] offs[4] = '{11'h400, 11'h3ff, 11'h000, 11'h000};
  logic [7:0]  wk;
  cru_exp_t    rq[$];
  cru_exp_t    cur;
  logic [1:0]  bq[$];
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          pulses      = 0;
  int          p0;
  logic [1:0]  ph_cnt = 2'h0;
  logic [31:0] seed = 32'd16214;

  always #5 clk = ~clk;

  cru_call_return_unit uut (
    .core_clk_i      (clk),
    .rst_i           (rst),
    .s_axi_awvalid_i (awv),
    .s_axi_awready_o (awr),
    .s_axi_awaddr_i  (awa),
    .s_axi_wvalid_i  (wv),
    .s_axi_wready_o  (wr),
    .s_axi_wdata_i   (wd),
    .s_axi_wstrb_i   (4'hf),
    .s_axi_bvalid_o  (bv),
    .s_axi_bready_i  (bry),
    .s_axi_bresp_o   (br),
    .s_axi_arvalid_i (arv),
    .s_axi_arready_o (arr),
    .s_axi_araddr_i  (ara),
    .s_axi_rvalid_o  (rv),
    .s_axi_rready_i  (rry),
    .s_axi_rdata_o   (rd),
    .s_axi_rresp_o   (rr),
    .pc_o            (pc),
    .working_o       (wk),
    .phase_o         (ph),
    .busy_o          (busy),
    .soft_reset_o    (srst)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic give_up(input string nm);
    error_cnt++;
    $display("MISMATCH %s expected answer seen timeout", nm);
    end_of_test();
  endtask

  // write, holding each channel until its own ready
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] e = cru_pkg::RESP_OKAY);
    int k;
    k = 0;
    @(posedge clk);
    bq.push_back(e);
    awv <= 1'b1;
    awa <= a;
    wv  <= 1'b1;
    wd  <= d;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (awv && awr)
        awv <= 1'b0;
      if (wv && wr)
        wv <= 1'b0;
    end while (bv !== 1'b1 && k < 50);
    if (bv !== 1'b1)
      give_up("bvalid");
    bry <= 1'b0;
  endtask

  task automatic rd_reg(input string nm, input logic [7:0] a,
                        input logic [31:0] e,
                        input logic [31:0] m = 32'hffffffff,
                        input logic [1:0] er = cru_pkg::RESP_OKAY);
    int k;
    k = 0;
    @(posedge clk);
    rq.push_back('{nm, e & m, m, er});
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (arv && arr)
        arv <= 1'b0;
    end while (rv !== 1'b1 && k < 50);
    if (rv !== 1'b1)
      give_up(nm);
    rry <= 1'b0;
  endtask

  // busy length after the response, in clocks
  task automatic settle(input int lo, input int hi);
    int c;
    c = 0;
    while (busy !== 1'b0 && c < 40) begin
      @(posedge clk);
      c++;
    end
    if (busy !== 1'b0)
      give_up("busy");
    cmp("busy span", 32'h1, {31'h0, (c >= lo && c <= hi)});
  endtask

  task automatic run(input logic [15:0] w, input int lo, input int hi);
    wr_reg(cru_pkg::OFF_INSTR, {16'h0, w});
    settle(lo, hi);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // monitor takes the oldest note per answer
  always @(posedge clk) begin
    // phase runs free from reset, untouched by soft reset
    if (!rst)
      cmp("phase pin", {30'h0, ph_cnt}, {30'h0, ph});
    ph_cnt <= rst ? 2'h0 : ph_cnt + 2'h1;
    if (bv && bry)
      cmp("bresp", (bq.size() > 0) ? {30'h0, bq.pop_front()} : 32'hx,
          {30'h0, br});
    if (rv && rry) begin
      cur = rq.pop_front();
      cmp({cur.name, " data"}, cur.data, rd & cur.mask);
      cmp({cur.name, " resp"}, {30'h0, cur.resp}, {30'h0, rr});
    end
    if (srst)
      pulses++;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg("pc", cru_pkg::OFF_PC, 32'h0);
    rd_reg("work", cru_pkg::OFF_WORK, 32'h0, 32'hfffff);
    rd_reg("stack", cru_pkg::OFF_STACK, 32'h0, 32'h1f1fffff);
    rd_reg("ctrl", cru_pkg::OFF_CTRL, 32'h0, 32'h103);
    rd_reg("hole", 8'h1c, 32'h0, 32'hffffffff, cru_pkg::RESP_SLVERR);
    wr_reg(cru_pkg::OFF_STACK, 32'h5, cru_pkg::RESP_SLVERR);
    wr_reg(cru_pkg::OFF_LATCH, 32'h1a5c);
    foreach (offs[i]) begin
      r = rnd();
      pc0 = {1'b0, r[31:13], 1'b0};
      n = (i < 3) ? offs[i] : r[10:0];
      wr_reg(cru_pkg::OFF_PC, {11'h0, pc0});
      run({5'h1b, n}, 9, 12);
      top[i] = pc0 + 21'h2;
      rd_reg("call pc", cru_pkg::OFF_PC,
             {11'h0, top[i] + {{9{n[10]}}, n, 1'b0}});
      cmp("pc pin", {11'h0, top[i] + {{9{n[10]}}, n, 1'b0}},
          {11'h0, pc});
      rd_reg("push", cru_pkg::OFF_STACK,
             {3'h0, 5'(i + 1), 3'h0, top[i]});
    end
    r = rnd();
    run({8'h0c, r[7:0]}, 9, 12);
    rd_reg("lit pc", cru_pkg::OFF_PC, {11'h0, top[3]});
    rd_reg("lit w", cru_pkg::OFF_WORK, {24'h0, r[7:0]}, 32'hfffff);
    cmp("work pin", {24'h0, r[7:0]}, {24'h0, wk});
    rd_reg("latch", cru_pkg::OFF_LATCH, 32'h1a5c, 32'h1fff);
    wr_reg(cru_pkg::OFF_CTRL, 32'h0);
    wr_reg(cru_pkg::OFF_SHADOW, 32'h7a533);
    wr_reg(cru_pkg::OFF_WORK, 32'h31122);
    run(16'h0010, 9, 12);
    rd_reg("ret pc", cru_pkg::OFF_PC, {11'h0, top[2]});
    rd_reg("slow w", cru_pkg::OFF_WORK, 32'h31122, 32'hfffff);
    rd_reg("enable", cru_pkg::OFF_CTRL, 32'h1, 32'h3);
    run(16'h0011, 9, 12);
    rd_reg("ret pc", cru_pkg::OFF_PC, {11'h0, top[1]});
    rd_reg("fast w", cru_pkg::OFF_WORK, 32'h7a533, 32'hfffff);
    rd_reg("enable", cru_pkg::OFF_CTRL, 32'h3, 32'h3);
    rd_reg("latch", cru_pkg::OFF_LATCH, 32'h1a5c, 32'h1fff);
    rd_reg("pop", cru_pkg::OFF_STACK, {8'h1, 3'h0, top[0]});
    // write refused while a call runs
    wr_reg(cru_pkg::OFF_INSTR, 32'hd800);
    wr_reg(cru_pkg::OFF_WORK, 32'h0, cru_pkg::RESP_SLVERR);
    settle(0, 13);
    rd_reg("kept w", cru_pkg::OFF_WORK, 32'h7a533, 32'hfffff);
    p0 = pulses;
    run(16'h00ff, 5, 8);
    rd_reg("rst pc", cru_pkg::OFF_PC, 32'h0);
    rd_reg("rst w", cru_pkg::OFF_WORK, 32'h0, 32'hfffff);
    rd_reg("rst shd", cru_pkg::OFF_SHADOW, 32'h0, 32'hfffff);
    rd_reg("rst lat", cru_pkg::OFF_LATCH, 32'h0, 32'h1fff);
    rd_reg("rst stk", cru_pkg::OFF_STACK, 32'h0, 32'h1f1fffff);
    rd_reg("rst en", cru_pkg::OFF_CTRL, 32'h0, 32'h3);
    cmp("reset pulses", 32'h1, 32'(pulses - p0));
    end_of_test();
  end
endmodule
`default_nettype wire
